// ---- core/iew_line_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module iew_line_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pins
  input  wire logic scl,
  input  wire logic sda_i,
  input  wire logic cs_lo,
  input  wire logic cs_hi,
  input  wire logic wp,
  // conditioned events
  iew_link_if.src   link
);

  typedef struct packed {
    logic [iew_pkg::PIN_N-1:0] s1;
    logic [iew_pkg::PIN_N-1:0] s2;
    logic [1:0]                s3;
  } iew_sync_type;

  iew_sync_type st;
  iew_sync_type next_st;

  // s1 is read only by s2; edges come from s2 against s3
  always_comb begin
    next_st    = st;
    next_st.s1 = {wp, cs_hi, cs_lo, sda_i, scl};
    next_st.s2 = st.s1;
    next_st.s3 = {st.s2[iew_pkg::PIN_SDA], st.s2[iew_pkg::PIN_SCL]};
  end

  // idle-high reset keeps a false start away after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  logic scl_hold;
  assign scl_hold      = st.s2[iew_pkg::PIN_SCL] & st.s3[iew_pkg::PIN_SCL];
  assign link.scl_rise = st.s2[iew_pkg::PIN_SCL] & ~st.s3[iew_pkg::PIN_SCL];
  assign link.scl_fall = ~st.s2[iew_pkg::PIN_SCL] & st.s3[iew_pkg::PIN_SCL];
  assign link.start    = scl_hold & st.s3[iew_pkg::PIN_SDA] & ~st.s2[iew_pkg::PIN_SDA]; // RQ1
  assign link.stop     = scl_hold & ~st.s3[iew_pkg::PIN_SDA] & st.s2[iew_pkg::PIN_SDA]; // RQ2
  assign link.sda      = st.s2[iew_pkg::PIN_SDA];
  assign link.wp       = st.s2[iew_pkg::PIN_WP];
  assign link.cs       = {st.s2[iew_pkg::PIN_CSH], st.s2[iew_pkg::PIN_CSL]};

endmodule
`default_nettype wire

// ---- core/iew_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface iew_link_if;
  logic       scl_rise;
  logic       scl_fall;
  logic       sda;
  logic       start;
  logic       stop;
  logic       wp;
  logic [1:0] cs;

  modport src (output scl_rise, scl_fall, sda, start, stop, wp, cs);
  modport dst (input scl_rise, scl_fall, sda, start, stop, wp, cs);
endinterface
`default_nettype wire

// ---- core/iew_pkg.sv ----
package iew_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int WRITE_TIME_NS = 5000000;
  localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;

  // select byte layout
  localparam logic [3:0] TYPE_MAIN = 4'ha;
  localparam logic [3:0] TYPE_ID   = 4'hb;
  localparam int         TYPE_MSB  = 7;
  localparam int         TYPE_LSB  = 4;
  localparam int         CS_MSB    = 3;
  localparam int         CS_LSB    = 2;
  localparam int         TOP_POS   = 1;
  localparam int         RW_POS    = 0;

  // address and data fields
  localparam int         LOCK_POS      = 2;
  localparam int         LOCK_DATA_POS = 1;
  localparam logic [3:0] BYTE_BITS     = 4'h8;

  // synchroniser pin slots
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_CSL = 2;
  localparam int PIN_CSH = 3;
  localparam int PIN_WP  = 4;
  localparam int PIN_N   = 5;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEL,
    ST_AHI,
    ST_ALO,
    ST_DATA,
    ST_SKIP,
    ST_BUSY
  } iew_state_type;

  function automatic logic iew_sel_match(input logic [7:0] b, input logic [1:0] cs);
    return (b[TYPE_MSB:TYPE_LSB] == TYPE_MAIN || b[TYPE_MSB:TYPE_LSB] == TYPE_ID)
           && b[CS_MSB:CS_LSB] == cs;
  endfunction

endpackage

// ---- core/iew_top.sv ----
// What this block does
// RQ1: start is sda fall while scl high
// RQ2: stop is sda rise, ends the exchange
// RQ3: sample sda on each scl rise
// RQ4: master changes sda only while scl low
// RQ5: receiver pulls sda low in ninth slot
// RQ6: select byte msb first, type, cs, a16, dir
// RQ7: respond only when cs bits match pins
// RQ8: direction bit one reads, zero writes; a read select is acked, then skipped with no data driven
// RQ9: ack match; mismatch releases bus, standby
// RQ10: write takes two acked address bytes
// RQ11: seventeen-bit address, top bit from select
// RQ12: write starts only on stop after data ack
// RQ13: counter points past last written byte
// RQ14: busy: sda released, all traffic ignored
// RQ15: write protect high nacks every data byte
// RQ16: page write wraps within same page
// RQ17: page counter steps after each data byte
// RQ18: id page write uses page protocol
// RQ19: locked id page nacks its data bytes
// RQ20: lock command sets permanent id lock; here the lock clears on reset
// RQ21: writes rewrite whole four-byte ecc group; here only loaded bytes go out, each with its group address
// RQ22: busy select unacked, acked when done
// RQ23: protected writes still ack select, address
// RQ24: write protect low or open enables writes
// RQ25: open chip selects read as zero
`timescale 1ns/1ps
`default_nettype none
module iew_top #(
  parameter int unsigned TW_CYCLES = iew_pkg::WRITE_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // two-wire link
  input  wire logic        scl,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_b,
  // straps
  input  wire logic        write_protect_input,
  input  wire logic        chip_select_pin_high,
  input  wire logic        chip_select_pin_low,
  // array write port
  output logic             mem_wr,
  output logic             mem_wr_id,
  output logic [16:0]      mem_wr_addr,
  output logic [7:0]       mem_wr_data,
  output logic [14:0]      mem_grp_addr,
  // status
  output logic [16:0]      mem_addr_counter,
  output logic             busy,
  output logic             id_locked
);

  logic [1:0] rst_q;
  logic       rst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q <= '0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  iew_link_if link ();

  iew_line_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .scl   (scl),
    .sda_i (sda_i),
    .cs_lo (chip_select_pin_low),
    .cs_hi (chip_select_pin_high),
    .wp    (write_protect_input),
    .link  (link.src)
  );

  typedef struct packed {
    iew_pkg::iew_state_type state;
    logic [3:0]             bitcnt;
    logic [7:0]             shreg;
    logic                   ack;
    logic                   ack_slot;
    logic                   after_ack;
    logic                   id_sel;
    logic [8:0]             page;
    logic [7:0]             low;
    logic                   got;
    logic                   lock_req;
    logic                   locked;
    logic [255:0][7:0]      wbuf;
    logic [255:0]           wmask;
    logic [8:0]             walk;
    logic [31:0]            timer;
    logic                   wr;
    logic                   wr_id;
    logic [16:0]            wr_addr;
    logic [7:0]             wr_data;
  } iew_core_type;

  iew_core_type st;
  iew_core_type next_st;

  logic byte_end;
  logic accept;
  logic is_lock;
  logic commit;

  assign byte_end = link.scl_fall && !st.ack_slot && st.bitcnt == iew_pkg::BYTE_BITS;
  assign accept   = !link.wp && !(st.id_sel && st.locked); // RQ15 RQ19 RQ24
  assign is_lock  = st.id_sel && st.page[iew_pkg::LOCK_POS]; // RQ20
  assign commit   = st.state == iew_pkg::ST_DATA && st.after_ack && st.got; // RQ12

  always_comb begin
    next_st    = st;
    next_st.wr = 1'b0;
    case (st.state)
      iew_pkg::ST_BUSY: begin
        // start and stop are not looked at while busy
        if (!st.walk[8]) begin
          if (st.wmask[st.walk[7:0]]) begin
            next_st.wr      = 1'b1;
            next_st.wr_id   = st.id_sel;
            next_st.wr_addr = {st.page, st.walk[7:0]};
            next_st.wr_data = st.wbuf[st.walk[7:0]];
          end
          next_st.walk = st.walk + 9'h001;
        end
        if (st.timer != '0) begin
          next_st.timer = st.timer - 32'h1;
        end else if (st.walk[8]) begin // RQ14 RQ22
          next_st.state    = iew_pkg::ST_IDLE;
          next_st.wmask    = '0;
          next_st.lock_req = 1'b0;
          if (st.lock_req) begin
            next_st.locked = 1'b1; // RQ20
          end
        end
      end
      iew_pkg::ST_IDLE: begin
        if (link.start) begin // RQ1
          next_st.state     = iew_pkg::ST_SEL;
          next_st.bitcnt    = '0;
          next_st.ack_slot  = 1'b0;
          next_st.after_ack = 1'b0;
        end
      end
      default: begin
        if (link.start) begin // RQ1
          // a repeated start drops any unwritten page data
          next_st.state     = iew_pkg::ST_SEL;
          next_st.bitcnt    = '0;
          next_st.ack       = 1'b0;
          next_st.ack_slot  = 1'b0;
          next_st.after_ack = 1'b0;
          next_st.got       = 1'b0;
          next_st.lock_req  = 1'b0;
          next_st.wmask     = '0;
        end else if (link.stop) begin // RQ2
          next_st.ack      = 1'b0;
          next_st.ack_slot = 1'b0;
          if (commit) begin // RQ12
            next_st.state = iew_pkg::ST_BUSY;
            next_st.walk  = '0;
            next_st.timer = TW_CYCLES - 32'h1;
          end else begin
            next_st.state    = iew_pkg::ST_IDLE;
            next_st.wmask    = '0;
            next_st.lock_req = 1'b0;
          end
        end else begin
          if (link.scl_rise && !st.ack_slot && st.bitcnt != iew_pkg::BYTE_BITS) begin
            next_st.shreg     = {st.shreg[6:0], link.sda}; // RQ3 RQ6
            next_st.bitcnt    = st.bitcnt + 4'h1;
            // the rise that opens the tenth slot must not lose the stop window
            next_st.after_ack = st.after_ack && st.bitcnt == '0; // RQ12
          end
          if (link.scl_fall && st.ack_slot) begin // RQ5
            next_st.ack       = 1'b0;
            next_st.ack_slot  = 1'b0;
            next_st.bitcnt    = '0;
            next_st.after_ack = st.state == iew_pkg::ST_DATA;
          end else if (byte_end && st.state != iew_pkg::ST_SKIP) begin
            next_st.ack_slot = 1'b1;
            case (st.state)
              iew_pkg::ST_SEL: begin
                if (!iew_pkg::iew_sel_match(st.shreg, link.cs)) begin // RQ7 RQ9 RQ25
                  next_st.state    = iew_pkg::ST_SKIP;
                  next_st.ack_slot = 1'b0;
                end else begin
                  next_st.ack      = 1'b1; // RQ9 RQ22 RQ23
                  next_st.id_sel   = st.shreg[iew_pkg::TYPE_LSB]; // RQ18
                  next_st.page[8]  = st.shreg[iew_pkg::TOP_POS]; // RQ11
                  next_st.got      = 1'b0;
                  next_st.lock_req = 1'b0;
                  next_st.wmask    = '0;
                  // the read path lives elsewhere; this end steps aside
                  if (st.shreg[iew_pkg::RW_POS]) begin // RQ8
                    next_st.state = iew_pkg::ST_SKIP;
                  end else begin
                    next_st.state = iew_pkg::ST_AHI; // RQ10
                  end
                end
              end
              iew_pkg::ST_AHI: begin
                next_st.ack       = 1'b1; // RQ10 RQ23
                next_st.page[7:0] = st.shreg;
                next_st.state     = iew_pkg::ST_ALO;
              end
              iew_pkg::ST_ALO: begin
                next_st.ack   = 1'b1; // RQ10 RQ23
                next_st.low   = st.shreg; // RQ11
                next_st.state = iew_pkg::ST_DATA;
              end
              iew_pkg::ST_DATA: begin
                if (accept) begin
                  next_st.ack = 1'b1;
                  next_st.got = 1'b1;
                  if (is_lock) begin // RQ20
                    next_st.lock_req = !st.got && st.shreg[iew_pkg::LOCK_DATA_POS];
                  end else begin
                    next_st.wbuf[st.low]  = st.shreg; // RQ16 RQ18
                    next_st.wmask[st.low] = 1'b1;
                    next_st.low           = st.low + 8'h01; // RQ16 RQ17 RQ13
                  end
                end
              end
              default: begin
                next_st.ack_slot = 1'b0;
              end
            endcase
          end
        end
      end
    endcase
  end

  // id lock is volatile here; a real part keeps it in the array
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sda_o            = 1'b0;
  assign sda_oe_b         = ~st.ack; // RQ5 RQ14
  assign busy             = st.state == iew_pkg::ST_BUSY;
  assign id_locked        = st.locked;
  assign mem_wr           = st.wr;
  assign mem_wr_id        = st.wr_id;
  assign mem_wr_addr      = st.wr_addr;
  assign mem_wr_data      = st.wr_data;
  assign mem_grp_addr     = st.wr_addr[16:2]; // RQ21
  assign mem_addr_counter = {st.page, st.low}; // RQ13

  property p_busy_quiet;
    @(posedge clk) disable iff (!rst_n) busy |-> sda_oe_b ##1 st.state != iew_pkg::ST_SEL;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("busy but sda driven"); // RQ14

  property p_start_sel;
    @(posedge clk) disable iff (!rst_n) (link.start && !busy) |=> st.state == iew_pkg::ST_SEL;
  endproperty
  a_start_sel: assert property (p_start_sel) else $error("start not taken"); // RQ1

  property p_stop_end;
    @(posedge clk) disable iff (!rst_n)
      (link.stop && !link.start && !busy && st.state != iew_pkg::ST_IDLE && !commit)
      |=> st.state == iew_pkg::ST_IDLE && sda_oe_b;
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("stop did not end exchange"); // RQ2

  property p_sample;
    @(posedge clk) disable iff (!rst_n)
      (st.state == iew_pkg::ST_SEL && link.scl_rise && !link.start && !link.stop
       && !st.ack_slot && st.bitcnt < iew_pkg::BYTE_BITS)
      |=> st.shreg[0] == $past(link.sda) && st.bitcnt == $past(st.bitcnt) + 4'h1;
  endproperty
  a_sample: assert property (p_sample) else $error("bit not sampled on scl rise"); // RQ3

  property p_mismatch;
    @(posedge clk) disable iff (!rst_n)
      (st.state == iew_pkg::ST_SEL && byte_end && !link.start && !link.stop
       && st.shreg[iew_pkg::CS_MSB:iew_pkg::CS_LSB] != link.cs)
      |=> st.state == iew_pkg::ST_SKIP && sda_oe_b [*2];
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatched select acked"); // RQ9

  property p_wp_nack;
    @(posedge clk) disable iff (!rst_n)
      (st.state == iew_pkg::ST_DATA && byte_end && link.wp && !link.start && !link.stop)
      |=> sda_oe_b && $stable(st.wmask) && !st.got == !$past(st.got);
  endproperty
  a_wp_nack: assert property (p_wp_nack) else $error("protected data byte acked"); // RQ15

  property p_addr_ack;
    @(posedge clk) disable iff (!rst_n)
      (st.state inside {iew_pkg::ST_AHI, iew_pkg::ST_ALO} && byte_end
       && !link.start && !link.stop)
      |=> !sda_oe_b && st.ack_slot;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address byte not acked"); // RQ23

  property p_commit;
    @(posedge clk) disable iff (!rst_n)
      (commit && link.stop && !link.start) |=> busy ##1 busy;
  endproperty
  a_commit: assert property (p_commit) else $error("stop after data ack did not write"); // RQ12

  property p_page_step;
    @(posedge clk) disable iff (!rst_n)
      (st.state == iew_pkg::ST_DATA && byte_end && accept && !is_lock
       && !link.start && !link.stop)
      |=> st.low == $past(st.low) + 8'h01 && st.page == $past(st.page);
  endproperty
  a_page_step: assert property (p_page_step) else $error("page counter did not wrap-step"); // RQ17

  property p_ack_release;
    @(posedge clk) disable iff (!rst_n)
      (st.ack_slot && link.scl_fall && !link.start && !link.stop && !busy)
      |=> sda_oe_b && !st.ack_slot;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack held past ninth slot"); // RQ5

  property p_lock_set;
    @(posedge clk) disable iff (!rst_n)
      (busy && st.lock_req && st.timer == '0 && st.walk[8])
      |=> id_locked && !busy;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock write did not id_page_lock_command page"); // RQ20

  property p_locked_nack;
    @(posedge clk) disable iff (!rst_n)
      (st.state == iew_pkg::ST_DATA && byte_end && st.id_sel && st.locked
       && !link.start && !link.stop)
      |=> sda_oe_b && $stable(st.wmask) && $stable(st.low);
  endproperty
  a_locked_nack: assert property (p_locked_nack) else $error("locked id page byte acked"); // RQ19

  property p_no_commit;
    @(posedge clk) disable iff (!rst_n)
      (link.stop && !commit && !busy)
      |=> !busy;
  endproperty
  a_no_commit: assert property (p_no_commit) else $error("stop off the tenth slot wrote"); // RQ12

endmodule
`default_nettype wire

// ---- test/iew_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module iew_master_model (
  // clock
  input  wire logic clk,
  // link
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_m
);
  // scl stands high between frames; each bit takes 8 clk, 800 ns
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic start();
    sda_m <= 1'b1;
    hold(3);
    scl <= 1'b1;
    hold(4);
    sda_m <= 1'b0;
    hold(4);
    scl <= 1'b0;
    hold(1);
  endtask

  // sda moves one clk after scl falls, far from the rising edge
  task automatic bit_io(input logic b, output logic s);
    sda_m <= b;
    hold(3);
    scl <= 1'b1;
    hold(1);
    s = sda_line;
    hold(3);
    scl <= 1'b0;
    hold(1);
  endtask

  task automatic xfer(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask

  task automatic stop();
    sda_m <= 1'b0;
    hold(3);
    scl <= 1'b1;
    hold(4);
    sda_m <= 1'b1;
    hold(4);
  endtask
endmodule
`default_nettype wire

// ---- test/iew_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module iew_top_tb;
  localparam int unsigned TW = 400;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        wp = 1'b0;
  logic        csh = 1'b0;
  logic        csl = 1'b0;
  logic        scl, sda_m, sda_line, sda_o, sda_oe_b;
  logic        mem_wr, mem_wr_id, busy, id_locked;
  logic [16:0] mem_wr_addr, mem_addr_counter;
  logic [7:0]  mem_wr_data;
  logic [14:0] mem_grp_addr;
  logic [40:0] wq[$];
  int          n_errors = 0;
  int          num_checks = 0;

  always #50 clk = ~clk;
  // pull-up: released line reads high
  assign sda_line = sda_m & (sda_oe_b | sda_o);

  iew_top #(.TW_CYCLES(TW)) u_iew_top (
    .clk(clk), .rst_b(rst_b), .scl(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_b(sda_oe_b), .write_protect_input(wp), .chip_select_pin_high(csh),
    .chip_select_pin_low(csl), .mem_wr(mem_wr), .mem_wr_id(mem_wr_id),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_grp_addr(mem_grp_addr),
    .mem_addr_counter(mem_addr_counter), .busy(busy), .id_locked(id_locked));

  iew_master_model u_iew_master_model (
    .clk(clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));

  always @(posedge clk) begin
    if (mem_wr === 1'b1) begin
      wq.push_back({mem_wr_id, mem_wr_addr, mem_wr_data, mem_grp_addr});
    end
  end

  function automatic logic [40:0] ex(input logic id, input logic [16:0] a, input logic [7:0] d);
    return {id, a, d, a[16:2]};
  endfunction

  task automatic send(input logic [7:0] b, input logic exp);
    logic ack;
    u_iew_master_model.xfer(b, ack);
    `CHK(ack, exp)
  endtask

  task automatic frame(input logic [7:0] s, input logic [7:0] h, input logic [7:0] l);
    wq.delete();
    u_iew_master_model.start();
    send(s, 1'b1);
    send(h, 1'b1);
    send(l, 1'b1);
  endtask

  task automatic stop_wait();
    u_iew_master_model.stop();
    repeat (6) @(posedge clk);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    `CHK(busy, 1'b0)
  endtask

  task automatic t_byte();
    frame(8'ha2, 8'h23, 8'h45);
    send(8'ha5, 1'b1);
    stop_wait();
    `CHK(busy, 1'b1)
    `CHK(mem_addr_counter, 17'h12346)
    u_iew_master_model.start();
    send(8'ha0, 1'b0);
    u_iew_master_model.stop();
    wait_done();
    `CHK(wq.size(), 1)
    `CHK(wq[0], ex(1'b0, 17'h12345, 8'ha5))
    u_iew_master_model.start();
    send(8'ha0, 1'b1);
    stop_wait();
    `CHK(busy, 1'b0)
  endtask

  task automatic t_page();
    frame(8'ha0, 8'h02, 8'hfe);
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    send(8'h33, 1'b1);
    stop_wait();
    `CHK(mem_addr_counter, 17'h00201)
    wait_done();
    `CHK(wq.size(), 3)
    `CHK(wq[0], ex(1'b0, 17'h00200, 8'h33))
    `CHK(wq[1], ex(1'b0, 17'h002fe, 8'h11))
    `CHK(wq[2], ex(1'b0, 17'h002ff, 8'h22))
  endtask

  task automatic t_sel();
    logic s;
    csh <= 1'b1;
    repeat (8) @(posedge clk);
    u_iew_master_model.start();
    send(8'ha0, 1'b0);
    u_iew_master_model.stop();
    frame(8'ha8, 8'h00, 8'h10);
    send(8'h00, 1'b1);
    for (int i = 0; i < 4; i++) begin
      u_iew_master_model.bit_io(1'b0, s);
    end
    stop_wait();
    `CHK(busy, 1'b0)
    `CHK(wq.size(), 0)
    u_iew_master_model.start();
    send(8'ha9, 1'b1);
    stop_wait();
    `CHK(busy, 1'b0)
    csh <= 1'b0;
  endtask

  task automatic t_wp();
    wp <= 1'b1;
    frame(8'ha0, 8'h00, 8'h40);
    send(8'h5a, 1'b0);
    stop_wait();
    `CHK(busy, 1'b0)
    `CHK(wq.size(), 0)
    wp <= 1'b0;
  endtask

  task automatic t_id();
    frame(8'hb0, 8'h00, 8'h10);
    send(8'h3c, 1'b1);
    stop_wait();
    wait_done();
    `CHK(wq.size(), 1)
    `CHK(wq[0], ex(1'b1, 17'h00010, 8'h3c))
    frame(8'hb0, 8'h04, 8'h00);
    send(8'h02, 1'b1);
    stop_wait();
    wait_done();
    `CHK(id_locked, 1'b1)
    `CHK(wq.size(), 0)
    frame(8'hb0, 8'h00, 8'h10);
    send(8'h77, 1'b0);
    stop_wait();
    `CHK(busy, 1'b0)
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    t_byte();
    t_page();
    t_sel();
    t_wp();
    t_id();
    wrap_up();
  end

  // whole run needs well under 2 ms of link traffic and write cycles
  initial begin
    #5000000;
    n_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
